// >>> cbm_far.sv
// Far side model: local cache arrays, main memory and coherency fabric.
// Assumes each request is a level held until its one-cycle acknowledge.
`timescale 1ns/1ps
`default_nettype none
module cbm_far (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [1:0] lat_i,
  input wire logic hit_i,
  input wire logic dirty_i,
  input wire logic way_i,
  input wire logic [4:0] req_i,
  output logic [4:0] ack_o,
  output logic cm_hit_o,
  output logic cm_dirty_o,
  output logic cm_way_o,
  output logic [31:0] dc_rdata_o,
  output logic [31:0] mem_rdata_o
);
  // Channels: cache op, broadcast, data cache, memory, coherency.
  logic [1:0] wait_r [5];
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 5; i++) begin
      if (rst_i || !req_i[i] || ack_o[i]) begin
        wait_r[i] <= 2'h0;
        ack_o[i] <= 1'b0;
      end else if (wait_r[i] == lat_i) begin
        ack_o[i] <= 1'b1;
      end else begin
        wait_r[i] <= wait_r[i] + 2'h1;
      end
    end
  end
  // Answer lines are inverted outside an ack.
  assign cm_hit_o = ack_o[0] ? hit_i : !hit_i;
  assign cm_dirty_o = ack_o[0] ? dirty_i : !dirty_i;
  assign cm_way_o = ack_o[0] ? way_i : !way_i;
  assign dc_rdata_o = ack_o[2] ? 32'h5a5a_c3c3 : 32'ha5a5_3c3c;
  assign mem_rdata_o = ack_o[3] ? 32'h0f0f_1e1e : 32'hf0f0_e1e1;
endmodule : cbm_far
`default_nettype wire

// >>> cbm_pkg.sv
// Constants, encodings and state types shared by the cache block
// management logic.
// Assumes a tool that accepts SystemVerilog packages; nothing is imported.

package cbm_pkg;

  // ------------------------------------------------------------------
  // Special-purpose register addressing
  // ------------------------------------------------------------------
  localparam int GRP_W = 5;
  localparam int REG_W = 11;
  localparam logic [GRP_W-1:0] GRP_DCACHE = 5'h03;
  localparam logic [GRP_W-1:0] GRP_ICACHE = 5'h04;
  localparam logic [REG_W-1:0] REG_DC_WRITEBACK = 11'h004;
  localparam logic [REG_W-1:0] REG_DC_LOCK = 11'h005;
  localparam logic [REG_W-1:0] REG_IC_PREFETCH = 11'h001;
  localparam logic [REG_W-1:0] REG_IC_INVALIDATE = 11'h002;
  localparam logic [REG_W-1:0] REG_IC_LOCK = 11'h003;

  // Slot index of each block register inside the design.
  localparam int NUM_REGS = 5;
  localparam int SLOT_DWB = 0;
  localparam int SLOT_DLOCK = 1;
  localparam int SLOT_IPF = 2;
  localparam int SLOT_IINV = 3;
  localparam int SLOT_ILOCK = 4;

  // Every target_address field resets to zero.
  localparam logic [63:0] ADDR_RESET = 64'h0;

  // ------------------------------------------------------------------
  // Commands and states
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    CM_DPROBE = 3'h0,
    CM_DWB    = 3'h1,
    CM_IPROBE = 3'h2,
    CM_IINV   = 3'h3,
    CM_IFETCH = 3'h4
  } cbm_cmd_t;

  typedef enum logic [2:0] {
    OP_DWB    = 3'h0,
    OP_DLOCK  = 3'h1,
    OP_IPF    = 3'h2,
    OP_IINV   = 3'h3,
    OP_ILOCK  = 3'h4,
    OP_SN_DWB = 3'h5,
    OP_SN_INV = 3'h6
  } cbm_op_t;

  // Gray along idle, probe, act, broadcast.
  typedef enum logic [1:0] {
    E_IDLE  = 2'h0,
    E_PROBE = 2'h1,
    E_ACT   = 2'h3,
    E_BCAST = 2'h2
  } cbm_estate_t;

  // Gray along idle, coherency, cache, memory, done.
  typedef enum logic [2:0] {
    A_IDLE  = 3'h0,
    A_COH   = 3'h1,
    A_CACHE = 3'h3,
    A_MEM   = 3'h2,
    A_DONE  = 3'h6
  } cbm_astate_t;

endpackage : cbm_pkg

// >>> cbm_top.sv
// Cache block management registers, maintenance engine, lock bits and
// page-attribute routing of loads and stores.
// Assumes the core's SPR write port, load/store pipeline, local cache
// arrays, main memory and coherency fabric all run on clk_i.
//
// Notes on behaviour
// - Each block register is as wide as the address, 32 or 64 bits.
// - Writes are accepted from user and supervisor privilege alike.
// - Coherent write-back also asks every other processor to write back.
// - Non-coherent write-back writes the local block only when modified.
// - Write-back register address resets to zero.
// - Data lock write locks the matching local block; write-only, resets zero.
// - Refill into a fully locked set unlocks its least-recently-used way.
// - Instruction prefetch fetches the block; never alters program results.
// - Without the prefetch option, prefetch writes are silently dropped.
// - Coherent instruction invalidate reaches every processor.
// - Non-coherent invalidate hits only the local cache; resets to zero.
// - Instruction lock write locks the matching local block.
// - Instruction lock that misses locally does nothing.
// - Accesses to coherent pages raise the coherency signal first.
// - Non-coherent pages raise no coherency signalling.
// - Caching-inhibited accesses go straight to main memory.
// - Caching-inhibited data is never allocated into a cache.
// - Inhibited accesses are never merged across synchronisation.
// - Write-through stores update the data cache and memory.
// - Write-through stores are never merged across synchronisation.
// - Write-back page stores update only the local data cache.
// - Snoop requests from others are served for write-back coherency.
// - Maintenance traffic is never recorded and never raises exceptions.
// - Without a cache, maintenance writes are ignored without stalling.

`timescale 1ns/1ps
`default_nettype none

module cbm_top #(
  parameter int AW = 32,
  parameter int BLOCK_BYTES = 16,
  parameter int SETS = 64,
  parameter int WAYS = 2,
  parameter bit HAS_DCACHE = 1'b1,
  parameter bit HAS_ICACHE = 1'b1,
  parameter bit HAS_DC_LOCK = 1'b1,
  parameter bit HAS_IC_PREFETCH = 1'b1,
  parameter bit HAS_IC_LOCK = 1'b1,
  localparam int SETW = (SETS > 1) ? $clog2(SETS) : 1,
  localparam int WAYW = (WAYS > 1) ? $clog2(WAYS) : 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic coherency_required_i,
  // SPR write path.
  input wire logic spr_we_i,
  input wire logic [cbm_pkg::GRP_W-1:0] spr_grp_i,
  input wire logic [cbm_pkg::REG_W-1:0] spr_reg_i,
  input wire logic [AW-1:0] spr_wdata_i,
  output logic spr_stall_o,
  output logic busy_o,
  // Maintenance port to the local caches.
  output logic cm_req_o,
  output logic [2:0] cm_cmd_o,
  output logic [AW-1:0] cm_addr_o,
  input wire logic cm_ack_i,
  input wire logic cm_hit_i,
  input wire logic cm_dirty_i,
  input wire logic [WAYW-1:0] cm_way_i,
  // Broadcast to other processors.
  output logic bc_req_o,
  output logic bc_inv_o,
  output logic [AW-1:0] bc_addr_o,
  input wire logic bc_ack_i,
  // Snoop requests from other processors.
  input wire logic sn_req_i,
  input wire logic sn_inv_i,
  input wire logic [AW-1:0] sn_addr_i,
  output logic sn_ack_o,
  // Refill victim selection.
  input wire logic rf_valid_i,
  input wire logic rf_icache_i,
  input wire logic [SETW-1:0] rf_set_i,
  input wire logic [WAYW-1:0] rf_lru_way_i,
  output logic [WAYS-1:0] rf_lock_mask_o,
  // Load/store pipeline.
  input wire logic ls_req_i,
  input wire logic ls_we_i,
  input wire logic [AW-1:0] ls_addr_i,
  input wire logic [31:0] ls_wdata_i,
  input wire logic [3:0] ls_be_i,
  input wire logic coherent_page_attr_i,
  input wire logic caching_inhibit_attr_i,
  input wire logic writeback_page_attr_i,
  output logic ls_ack_o,
  output logic [31:0] ls_rdata_o,
  // Local data cache access.
  output logic dc_req_o,
  output logic dc_we_o,
  output logic dc_alloc_o,
  output logic [AW-1:0] dc_addr_o,
  output logic [31:0] dc_wdata_o,
  output logic [3:0] dc_be_o,
  input wire logic dc_ack_i,
  input wire logic [31:0] dc_rdata_i,
  // Main memory.
  output logic mem_req_o,
  output logic mem_we_o,
  output logic [AW-1:0] mem_addr_o,
  output logic [31:0] mem_wdata_o,
  output logic [3:0] mem_be_o,
  input wire logic mem_ack_i,
  input wire logic [31:0] mem_rdata_i,
  // Coherency signal for accesses to coherent pages.
  output logic coh_sig_o,
  input wire logic coh_ack_i
);

  localparam int OFFW = $clog2(BLOCK_BYTES);

  // ------------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------------
  if (AW != 32 && AW != 64) begin : g_bad_aw
    $error("cbm_top: AW must be 32 or 64");
  end
  if (BLOCK_BYTES < 4 || (1 << OFFW) != BLOCK_BYTES) begin : g_bad_blk
    $error("cbm_top: bad BLOCK_BYTES");
  end
  if ((1 << $clog2(SETS)) != SETS || WAYS < 1) begin : g_bad_geom
    $error("cbm_top: bad SETS or WAYS");
  end

  function automatic logic [AW-1:0] blk(input logic [AW-1:0] a);
    blk = {a[AW-1:OFFW], {OFFW{1'b0}}};
  endfunction : blk

  // ------------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------------
  // Privilege is not an input, so both levels may write.
  wire dc_grp = spr_we_i && spr_grp_i == cbm_pkg::GRP_DCACHE;
  wire ic_grp = spr_we_i && spr_grp_i == cbm_pkg::GRP_ICACHE;
  wire [cbm_pkg::NUM_REGS-1:0] impl;
  wire [cbm_pkg::NUM_REGS-1:0] hit_w;
  wire [cbm_pkg::NUM_REGS-1:0] wr_w;
  logic [cbm_pkg::NUM_REGS-1:0] pend_r;
  logic [cbm_pkg::NUM_REGS-1:0] pend_nxt;
  logic [cbm_pkg::NUM_REGS-1:0] take_w;
  logic [AW-1:0] addr_r [cbm_pkg::NUM_REGS];

  // A missing cache or option drops the write and never stalls.
  assign impl[cbm_pkg::SLOT_DWB] = HAS_DCACHE;
  assign impl[cbm_pkg::SLOT_DLOCK] = HAS_DCACHE && HAS_DC_LOCK;
  assign impl[cbm_pkg::SLOT_IPF] = HAS_ICACHE && HAS_IC_PREFETCH;
  assign impl[cbm_pkg::SLOT_IINV] = HAS_ICACHE;
  assign impl[cbm_pkg::SLOT_ILOCK] = HAS_ICACHE && HAS_IC_LOCK;

  assign hit_w[cbm_pkg::SLOT_DWB] =
    dc_grp && spr_reg_i == cbm_pkg::REG_DC_WRITEBACK;
  assign hit_w[cbm_pkg::SLOT_DLOCK] =
    dc_grp && spr_reg_i == cbm_pkg::REG_DC_LOCK;
  assign hit_w[cbm_pkg::SLOT_IPF] =
    ic_grp && spr_reg_i == cbm_pkg::REG_IC_PREFETCH;
  assign hit_w[cbm_pkg::SLOT_IINV] =
    ic_grp && spr_reg_i == cbm_pkg::REG_IC_INVALIDATE;
  assign hit_w[cbm_pkg::SLOT_ILOCK] =
    ic_grp && spr_reg_i == cbm_pkg::REG_IC_LOCK;

  // A second write to a register whose request is still queued waits.
  assign spr_stall_o = |(hit_w & impl & pend_r);
  assign wr_w = hit_w & impl & ~pend_r;
  assign pend_nxt = (pend_r & ~take_w) | wr_w;

  for (genvar r = 0; r < cbm_pkg::NUM_REGS; r++) begin : g_reg
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        addr_r[r] <= cbm_pkg::ADDR_RESET[AW-1:0];
      end else if (ce_i && wr_w[r]) begin
        addr_r[r] <= spr_wdata_i;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pend_r <= '0;
    end else if (ce_i) begin
      pend_r <= pend_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Maintenance engine
  // ------------------------------------------------------------------
  cbm_pkg::cbm_estate_t e_state_r;
  cbm_pkg::cbm_estate_t e_state_nxt;
  cbm_pkg::cbm_op_t e_op_r;
  cbm_pkg::cbm_op_t e_op_nxt;
  logic [AW-1:0] e_addr_r;
  logic [AW-1:0] e_addr_nxt;
  logic e_coh_r;
  logic e_coh_nxt;
  logic sn_ack_r;
  logic [WAYW-1:0] e_way_r;

  wire e_idle = e_state_r == cbm_pkg::E_IDLE;
  wire sn_take = e_idle && sn_req_i && !sn_ack_r;
  wire e_is_snoop = e_op_r == cbm_pkg::OP_SN_DWB ||
    e_op_r == cbm_pkg::OP_SN_INV;
  wire e_dside = e_op_r == cbm_pkg::OP_DWB ||
    e_op_r == cbm_pkg::OP_DLOCK || e_op_r == cbm_pkg::OP_SN_DWB;
  wire e_inv = e_op_r == cbm_pkg::OP_IINV || e_op_r == cbm_pkg::OP_SN_INV;
  wire e_lock = e_op_r == cbm_pkg::OP_DLOCK || e_op_r == cbm_pkg::OP_ILOCK;
  wire probe_ack = e_state_r == cbm_pkg::E_PROBE && cm_ack_i;
  wire act_ack = e_state_r == cbm_pkg::E_ACT && cm_ack_i;
  // Only a modified block is written back; only a hit is invalidated.
  wire need_act = cm_hit_i && !e_lock && (!e_dside || cm_dirty_i);
  wire e_finish = (probe_ack && !need_act && !e_coh_r) ||
    (act_ack && !e_coh_r) ||
    (e_state_r == cbm_pkg::E_BCAST && bc_ack_i);

  always_comb begin
    take_w = '0;
    e_state_nxt = e_state_r;
    e_op_nxt = e_op_r;
    e_addr_nxt = e_addr_r;
    e_coh_nxt = e_coh_r;
    case (e_state_r)
      cbm_pkg::E_IDLE: begin
        if (sn_take) begin
          e_op_nxt = sn_inv_i ? cbm_pkg::OP_SN_INV : cbm_pkg::OP_SN_DWB;
          e_addr_nxt = blk(sn_addr_i);
          e_coh_nxt = 1'b0;
          e_state_nxt = cbm_pkg::E_PROBE;
        end else if (pend_r != '0) begin
          for (int r = cbm_pkg::NUM_REGS - 1; r >= 0; r--) begin
            if (pend_r[r]) begin
              take_w = '0;
              take_w[r] = 1'b1;
              e_op_nxt = cbm_pkg::cbm_op_t'(r[2:0]);
              e_addr_nxt = blk(addr_r[r]);
            end
          end
          // Only write-back and invalidate are ever broadcast.
          e_coh_nxt = coherency_required_i &&
            (e_op_nxt == cbm_pkg::OP_DWB ||
             e_op_nxt == cbm_pkg::OP_IINV);
          e_state_nxt = e_op_nxt == cbm_pkg::OP_IPF ?
            cbm_pkg::E_ACT : cbm_pkg::E_PROBE;
        end
      end
      cbm_pkg::E_PROBE: begin
        if (cm_ack_i) begin
          if (need_act) begin
            e_state_nxt = cbm_pkg::E_ACT;
          end else if (e_coh_r) begin
            e_state_nxt = cbm_pkg::E_BCAST;
          end else begin
            e_state_nxt = cbm_pkg::E_IDLE;
          end
        end
      end
      cbm_pkg::E_ACT: begin
        if (cm_ack_i) begin
          e_state_nxt = e_coh_r ? cbm_pkg::E_BCAST : cbm_pkg::E_IDLE;
        end
      end
      cbm_pkg::E_BCAST: begin
        if (bc_ack_i) begin
          e_state_nxt = cbm_pkg::E_IDLE;
        end
      end
      default: begin
        e_state_nxt = cbm_pkg::E_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      e_state_r <= cbm_pkg::E_IDLE;
      e_op_r <= cbm_pkg::OP_DWB;
      e_addr_r <= cbm_pkg::ADDR_RESET[AW-1:0];
      e_coh_r <= 1'b0;
      e_way_r <= '0;
      sn_ack_r <= 1'b0;
    end else if (ce_i) begin
      e_state_r <= e_state_nxt;
      e_op_r <= e_op_nxt;
      e_addr_r <= e_addr_nxt;
      e_coh_r <= e_coh_nxt;
      sn_ack_r <= e_finish && e_is_snoop;
      if (probe_ack) begin
        e_way_r <= cm_way_i;
      end
    end
  end

  // No exception output; engine traffic never reaches load results.
  assign cm_req_o = e_state_r == cbm_pkg::E_PROBE ||
    e_state_r == cbm_pkg::E_ACT;
  assign cm_addr_o = e_addr_r;
  assign cm_cmd_o = e_state_r == cbm_pkg::E_PROBE ?
    (e_dside ? cbm_pkg::CM_DPROBE : cbm_pkg::CM_IPROBE) :
    (e_op_r == cbm_pkg::OP_IPF ? cbm_pkg::CM_IFETCH :
     e_inv ? cbm_pkg::CM_IINV : cbm_pkg::CM_DWB);
  assign bc_req_o = e_state_r == cbm_pkg::E_BCAST;
  assign bc_inv_o = e_inv;
  assign bc_addr_o = e_addr_r;
  assign sn_ack_o = sn_ack_r;
  assign busy_o = !e_idle || pend_r != '0;

  // ------------------------------------------------------------------
  // Lock bits
  // ------------------------------------------------------------------
  logic [WAYS-1:0] dlock_r [SETS];
  logic [WAYS-1:0] ilock_r [SETS];
  wire [SETW-1:0] e_set = e_addr_r[OFFW +: SETW];
  wire lock_hit = probe_ack && cm_hit_i && e_lock;
  wire dlock_set = lock_hit && e_op_r == cbm_pkg::OP_DLOCK;
  wire ilock_set = lock_hit && e_op_r == cbm_pkg::OP_ILOCK;
  // An invalidated block no longer holds a lock.
  wire ilock_clr = act_ack && e_inv;
  wire [WAYS-1:0] rf_row = rf_icache_i ? ilock_r[rf_set_i] :
    dlock_r[rf_set_i];
  wire rf_unlock = rf_valid_i && (&rf_row);
  wire [WAYS-1:0] lru_mask = WAYS'(1) << rf_lru_way_i;
  wire [WAYS-1:0] e_way_mask = WAYS'(1) << cm_way_i;
  wire [WAYS-1:0] e_old_mask = WAYS'(1) << e_way_r;

  assign rf_lock_mask_o = rf_row;

  for (genvar s = 0; s < SETS; s++) begin : g_lock
    wire at_e = e_set == SETW'(s);
    wire at_rf = rf_set_i == SETW'(s) && rf_unlock;
    wire [WAYS-1:0] d_clr = (at_rf && !rf_icache_i) ? lru_mask : '0;
    wire [WAYS-1:0] i_clr = ((at_rf && rf_icache_i) ? lru_mask : '0) |
      ((at_e && ilock_clr) ? e_old_mask : '0);
    wire [WAYS-1:0] d_set = (at_e && dlock_set) ? e_way_mask : '0;
    wire [WAYS-1:0] i_set = (at_e && ilock_set) ? e_way_mask : '0;
    always_ff @(posedge clk_i) begin
      if (rst_i) begin
        dlock_r[s] <= '0;
        ilock_r[s] <= '0;
      end else if (ce_i) begin
        dlock_r[s] <= (dlock_r[s] & ~d_clr) | d_set;
        ilock_r[s] <= (ilock_r[s] & ~i_clr) | i_set;
      end
    end
  end

  // ------------------------------------------------------------------
  // Load/store attribute routing
  // ------------------------------------------------------------------
  // Accesses are never combined, so none merges across a sync.
  cbm_pkg::cbm_astate_t a_state_r;
  cbm_pkg::cbm_astate_t a_state_nxt;
  logic a_we_r;
  logic a_cc_r;
  logic a_ci_r;
  logic a_wbc_r;
  logic [AW-1:0] a_addr_r;
  logic [31:0] a_wdata_r;
  logic [3:0] a_be_r;
  logic [31:0] rdata_r;

  wire a_take = a_state_r == cbm_pkg::A_IDLE && ls_req_i;
  // After the cache, only a write-through store continues to memory.
  wire a_thru = a_we_r && !a_wbc_r;

  always_comb begin
    a_state_nxt = a_state_r;
    case (a_state_r)
      cbm_pkg::A_IDLE: begin
        if (ls_req_i) begin
          if (coherent_page_attr_i) begin
            a_state_nxt = cbm_pkg::A_COH;
          end else if (caching_inhibit_attr_i || !HAS_DCACHE) begin
            a_state_nxt = cbm_pkg::A_MEM;
          end else begin
            a_state_nxt = cbm_pkg::A_CACHE;
          end
        end
      end
      cbm_pkg::A_COH: begin
        if (coh_ack_i) begin
          a_state_nxt = (a_ci_r || !HAS_DCACHE) ?
            cbm_pkg::A_MEM : cbm_pkg::A_CACHE;
        end
      end
      cbm_pkg::A_CACHE: begin
        if (dc_ack_i) begin
          a_state_nxt = a_thru ? cbm_pkg::A_MEM : cbm_pkg::A_DONE;
        end
      end
      cbm_pkg::A_MEM: begin
        if (mem_ack_i) begin
          a_state_nxt = cbm_pkg::A_DONE;
        end
      end
      cbm_pkg::A_DONE: begin
        a_state_nxt = cbm_pkg::A_IDLE;
      end
      default: begin
        a_state_nxt = cbm_pkg::A_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_state_r <= cbm_pkg::A_IDLE;
      a_we_r <= 1'b0;
      a_cc_r <= 1'b0;
      a_ci_r <= 1'b0;
      a_wbc_r <= 1'b0;
      a_addr_r <= cbm_pkg::ADDR_RESET[AW-1:0];
      a_wdata_r <= '0;
      a_be_r <= '0;
      rdata_r <= '0;
    end else if (ce_i) begin
      a_state_r <= a_state_nxt;
      if (a_take) begin
        a_we_r <= ls_we_i;
        a_cc_r <= coherent_page_attr_i;
        a_ci_r <= caching_inhibit_attr_i;
        a_wbc_r <= writeback_page_attr_i;
        a_addr_r <= ls_addr_i;
        a_wdata_r <= ls_wdata_i;
        a_be_r <= ls_be_i;
      end
      if (a_state_r == cbm_pkg::A_CACHE && dc_ack_i && !a_we_r) begin
        rdata_r <= dc_rdata_i;
      end else if (a_state_r == cbm_pkg::A_MEM && mem_ack_i && !a_we_r) begin
        rdata_r <= mem_rdata_i;
      end
    end
  end

  assign coh_sig_o = a_state_r == cbm_pkg::A_COH && a_cc_r;
  assign dc_req_o = a_state_r == cbm_pkg::A_CACHE;
  assign dc_we_o = a_we_r;
  // Allocation is held off too, guarding against a stale attribute.
  assign dc_alloc_o = !a_ci_r;
  assign dc_addr_o = a_addr_r;
  assign dc_wdata_o = a_wdata_r;
  assign dc_be_o = a_be_r;
  assign mem_req_o = a_state_r == cbm_pkg::A_MEM;
  assign mem_we_o = a_we_r;
  assign mem_addr_o = a_addr_r;
  assign mem_wdata_o = a_wdata_r;
  assign mem_be_o = a_be_r;
  assign ls_ack_o = a_state_r == cbm_pkg::A_DONE;
  assign ls_rdata_o = rdata_r;

endmodule : cbm_top

`default_nettype wire

// >>> cbm_top_sva.sv
// Checker for the cache block management top, bound from the testbench.
// Assumes ce_i stays high and a single clock domain.
`timescale 1ns/1ps
`default_nettype none
module cbm_top_sva #(
  parameter int AW = 32,
  parameter int BLOCK_BYTES = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic busy_o,
  input wire logic cm_req_o,
  input wire logic [2:0] cm_cmd_o,
  input wire logic [AW-1:0] cm_addr_o,
  input wire logic cm_ack_i,
  input wire logic cm_dirty_i,
  input wire logic sn_ack_o,
  input wire logic ls_req_i,
  input wire logic ls_we_i,
  input wire logic coherent_page_attr_i,
  input wire logic caching_inhibit_attr_i,
  input wire logic writeback_page_attr_i,
  input wire logic dc_req_o,
  input wire logic dc_ack_i,
  input wire logic mem_req_o,
  input wire logic mem_we_o,
  input wire logic coh_sig_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence wt_hit_s;
    ls_req_i && ls_we_i && !writeback_page_attr_i &&
      !caching_inhibit_attr_i && dc_req_o && dc_ack_i;
  endsequence
  rst_quiet_a: assert property (
    $fell(rst_i) |-> !busy_o && !cm_req_o && cm_addr_o == '0)
    else $error("reset not clean");
  cm_hold_a: assert property (cm_req_o && !cm_ack_i |=>
    cm_req_o && $stable(cm_cmd_o) && $stable(cm_addr_o))
    else $error("cm req unstable");
  blk_align_a: assert property (
    cm_req_o |-> (cm_addr_o & AW'(BLOCK_BYTES - 1)) == '0)
    else $error("cm addr unaligned");
  clean_nowb_a: assert property (
    cm_ack_i && cm_cmd_o == cbm_pkg::CM_DPROBE && !cm_dirty_i |=>
    !(cm_req_o && cm_cmd_o == cbm_pkg::CM_DWB))
    else $error("clean block written back");
  nc_nocoh_a: assert property (
    ls_req_i && !coherent_page_attr_i |-> !coh_sig_o)
    else $error("coh on plain page");
  ci_bypass_a: assert property (
    ls_req_i && caching_inhibit_attr_i |-> !dc_req_o)
    else $error("inhibited hit cache");
  wb_local_a: assert property (
    ls_req_i && ls_we_i && writeback_page_attr_i &&
    !caching_inhibit_attr_i |-> !mem_req_o)
    else $error("wb store hit memory");
  wt_store_a: assert property (wt_hit_s |=> mem_req_o && mem_we_o)
    else $error("wt store missed memory");
  sn_pulse_a: assert property (sn_ack_o |=> !sn_ack_o)
    else $error("snoop ack too long");
endmodule : cbm_top_sva
`default_nettype wire

// >>> tb.sv
// Self-checking bench for the cache block management top.
// Assumes cbm_pkg, cbm_top, cbm_far and the checker are compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic spr_we_i = 1'b0, coherency_required_i = 1'b0;
  logic [4:0] spr_grp_i = 5'h00;
  logic [10:0] spr_reg_i = 11'h000;
  logic [31:0] spr_wdata_i = 32'h0, sn_addr_i = 32'h0, ls_addr_i = 32'h0;
  logic sn_req_i = 1'b0, sn_inv_i = 1'b0, rf_valid_i = 1'b0;
  logic rf_icache_i = 1'b0, rf_lru_way_i = 1'b0;
  logic [5:0] rf_set_i = 6'h12;
  logic ls_req_i = 1'b0, ls_we_i = 1'b0, cc = 1'b0, ci = 1'b0, wb = 1'b0;
  logic [1:0] lat = 2'h0;
  logic hit = 1'b0, dirty = 1'b0, way = 1'b0;
  logic spr_stall_o, busy_o, cm_req_o, bc_req_o, sn_ack_o, ls_ack_o;
  logic dc_req_o, mem_req_o, coh_sig_o, cm_hit, cm_dirty, cm_way;
  logic [2:0] cm_cmd_o;
  logic [31:0] cm_addr_o, ls_rdata_o, dc_rdata, mem_rdata, cm_last;
  logic [1:0] rf_lock_mask_o;
  logic [4:0] ack;
  int error_cnt = 0, n_checks = 0, k;
  int n_cmd [8] = '{default: 0};
  int n_ack [5] = '{default: 0};
  always #12.5 clk_i = ~clk_i;
  cbm_top #(.AW(32)) dut_u (.clk_i, .rst_i, .ce_i(1'b1),
    .coherency_required_i, .spr_we_i, .spr_grp_i, .spr_reg_i,
    .spr_wdata_i, .spr_stall_o, .busy_o, .cm_req_o, .cm_cmd_o, .cm_addr_o,
    .cm_ack_i(ack[0]), .cm_hit_i(cm_hit), .cm_dirty_i(cm_dirty),
    .cm_way_i(cm_way), .bc_req_o, .bc_inv_o(), .bc_addr_o(),
    .bc_ack_i(ack[1]), .sn_req_i, .sn_inv_i, .sn_addr_i, .sn_ack_o,
    .rf_valid_i, .rf_icache_i, .rf_set_i, .rf_lru_way_i, .rf_lock_mask_o,
    .ls_req_i, .ls_we_i, .ls_addr_i, .ls_wdata_i(32'h1234_5678),
    .ls_be_i(4'hf), .coherent_page_attr_i(cc), .caching_inhibit_attr_i(ci),
    .writeback_page_attr_i(wb), .ls_ack_o, .ls_rdata_o, .dc_req_o,
    .dc_we_o(), .dc_alloc_o(), .dc_addr_o(), .dc_wdata_o(), .dc_be_o(),
    .dc_ack_i(ack[2]), .dc_rdata_i(dc_rdata), .mem_req_o, .mem_we_o(),
    .mem_addr_o(), .mem_wdata_o(), .mem_be_o(), .mem_ack_i(ack[3]),
    .mem_rdata_i(mem_rdata), .coh_sig_o, .coh_ack_i(ack[4]));
  cbm_far far_u (.clk_i, .rst_i, .lat_i(lat), .hit_i(hit),
    .dirty_i(dirty), .way_i(way),
    .req_i({coh_sig_o, mem_req_o, dc_req_o, bc_req_o, cm_req_o}),
    .ack_o(ack), .cm_hit_o(cm_hit), .cm_dirty_o(cm_dirty),
    .cm_way_o(cm_way), .dc_rdata_o(dc_rdata), .mem_rdata_o(mem_rdata));
  always @(posedge clk_i) begin
    for (int j = 0; j < 5; j++) if (ack[j]) n_ack[j]++;
    if (ack[0]) begin
      n_cmd[cm_cmd_o]++;
      cm_last = cm_addr_o;
    end
  end
  task automatic chk(input string what, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s exp %0h got %0h", what, exp, got);
    end
  endtask : chk
  task automatic summarize();
    if (error_cnt == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic wait_lo(input string what, ref logic sig, input logic v);
    k = 0;
    @(negedge clk_i);
    while (sig !== v && k < 100) begin
      @(negedge clk_i);
      k++;
    end
    if (k == 100) begin
      chk(what, 32'(sig), 32'(v));
      summarize();
    end
  endtask : wait_lo
  task automatic spr_wr(input logic [4:0] g, input logic [10:0] r,
                        input logic [31:0] a, input logic c);
    @(negedge clk_i);
    spr_we_i = 1'b1;
    spr_grp_i = g;
    spr_reg_i = r;
    spr_wdata_i = a;
    coherency_required_i = c;
    #1;
    chk("stall", 32'(spr_stall_o), 32'h0);
    @(negedge clk_i);
    spr_we_i = 1'b0;
    wait_lo("busy", busy_o, 1'b0);
  endtask : spr_wr
  task automatic t_reset();
    rst_i = 1'b1;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    #1;
    chk("busy", 32'(busy_o), 32'h0);
    chk("addr", cm_addr_o, 32'h0);
    chk("lock mask", 32'(rf_lock_mask_o), 32'h0);
  endtask : t_reset
  task automatic t_maint();
    logic [10:0] rg [8] = '{11'h004, 11'h004, 11'h004, 11'h002,
                            11'h002, 11'h001, 11'h003, 11'h000};
    logic [5:0] ex [8] = '{6'h23, 6'h03, 6'h01, 6'h2c,
                           6'h0c, 6'h10, 6'h04, 6'h00};
    logic [7:0] ic = 8'h78, co = 8'h09, hi = 8'h3f, di = 8'h03;
    logic [5:0] got;
    int b [8];
    int bb;
    for (int i = 0; i < 8; i++) begin
      hit = hi[i];
      dirty = di[i];
      lat = 2'(i % 3);
      b = n_cmd;
      bb = n_ack[1];
      spr_wr(ic[i] ? 5'h04 : 5'h03, rg[i], 32'h0000_0347, co[i]);
      for (int j = 0; j < 5; j++) got[j] = n_cmd[j] != b[j];
      got[5] = n_ack[1] != bb;
      chk("maint ops", 32'(got), 32'(ex[i]));
      if (ex[i] != 6'h00) chk("block", cm_last, 32'h0000_0340);
    end
  endtask : t_maint
  task automatic t_lock();
    hit = 1'b1;
    way = 1'b0;
    spr_wr(5'h03, 11'h005, 32'h0000_0128, 1'b0);
    chk("dlock", 32'(rf_lock_mask_o), 32'h1);
    way = 1'b1;
    spr_wr(5'h03, 11'h005, 32'h0000_012c, 1'b0);
    spr_wr(5'h04, 11'h003, 32'h0000_0120, 1'b0);
    chk("dlock", 32'(rf_lock_mask_o), 32'h3);
    rf_icache_i = 1'b1;
    #1;
    chk("ilock", 32'(rf_lock_mask_o), 32'h2);
    @(negedge clk_i);
    rf_icache_i = 1'b0;
    rf_lru_way_i = 1'b1;
    rf_valid_i = 1'b1;
    @(negedge clk_i);
    rf_valid_i = 1'b0;
    chk("refill unlock", 32'(rf_lock_mask_o), 32'h1);
  endtask : t_lock
  task automatic t_ls();
    logic [3:0] at [7] = '{4'h0, 4'h2, 4'h8, 4'h9, 4'h4, 4'hb, 4'he};
    logic [2:0] ex [7] = '{3'h1, 3'h2, 3'h3, 3'h1, 3'h5, 3'h2, 3'h6};
    int b [5];
    for (int i = 0; i < 7; i++) begin
      b = n_ack;
      @(negedge clk_i);
      {ls_we_i, cc, ci, wb} = at[i];
      ls_addr_i = 32'h0000_0a06 + 32'(i * 4);
      lat = 2'(i % 3);
      ls_req_i = 1'b1;
      wait_lo("ls ack", ls_ack_o, 1'b1);
      if (!at[i][3])
        chk("load data", ls_rdata_o,
            at[i][1] ? 32'h0f0f_1e1e : 32'h5a5a_c3c3);
      @(negedge clk_i);
      ls_req_i = 1'b0;
      chk("ls path", {n_ack[4] != b[4], n_ack[3] != b[3], n_ack[2] != b[2]},
          32'(ex[i]));
    end
  endtask : t_ls
  task automatic t_snoop();
    int b [8];
    hit = 1'b1;
    dirty = 1'b1;
    for (int s = 0; s < 2; s++) begin
      b = n_cmd;
      @(negedge clk_i);
      sn_req_i = 1'b1;
      sn_inv_i = s[0];
      sn_addr_i = 32'h0000_05a4;
      wait_lo("snoop ack", sn_ack_o, 1'b1);
      @(negedge clk_i);
      sn_req_i = 1'b0;
      chk("snoop op", n_cmd[s ? 3 : 1] - b[s ? 3 : 1], 32'h1);
    end
  endtask : t_snoop
  initial begin
    t_reset();
    t_maint();
    t_lock();
    t_reset();
    t_ls();
    t_snoop();
    summarize();
  end
endmodule : tb
bind cbm_top cbm_top_sva #(.AW(AW), .BLOCK_BYTES(BLOCK_BYTES)) sva_u (.*);
`default_nettype wire
